/* psc_top.sv */
// module: set/clear output control for a 32-pin programmable I/O port
`timescale 1ns/1ps
`default_nettype none
module psc_top
    import psc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // config space access
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [11:0] cfg_addr,
    input  wire logic        cfg_wide,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_ready,
    // pins
    input  wire logic [31:0] pin_in,
    output logic      [31:0] pin_out,
    output logic      [31:0] pin_oe_n
);
    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        logic        pend;
        psc_op_t     pend_op;
        logic [15:0] pend_data;
        logic        pend_rd;
        logic [15:0] rd_lo;
        logic        h_valid;
        logic        h_hi;
        psc_op_t     h_op;
        logic [15:0] h_data;
        logic [31:0] dir;
        logic [31:0] fnc;
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] rdata;
        logic        ready;
        logic [31:0] pout;
        logic [31:0] poe_n;
    } psc_st_t;

    psc_st_t st_r;
    psc_st_t st_nxt;

    logic [31:0] latch;
    logic        hit_hi;
    psc_op_t     dec_op;
    logic        dec_ok;
    logic [15:0] cur_lvl;

    psc_half_if u_if ();

    assign u_if.valid = st_r.h_valid;
    assign u_if.hi    = st_r.h_hi;
    assign u_if.op    = st_r.h_op;
    assign u_if.data  = st_r.h_data;

    psc_latch u_latch (
        .clk_sys (clk_sys),
        .rst     (rst),
        .upd     (u_if.dst),
        .dir_out (st_r.dir),
        .fnc_sel (st_r.fnc),
        .latch   (latch)
    );

    // ***************************************************
    // decode and split
    // ***************************************************
    always_comb begin
        st_nxt  = st_r;
        hit_hi  = cfg_addr[1];
        dec_ok  = 1'b1;
        dec_op  = OP_DATA;
        cur_lvl = 16'h0000;
        unique case ({cfg_addr[11:2], 2'b00})
            OFS_DATA_LO: dec_op = OP_DATA;
            OFS_SET_LO:  dec_op = OP_SET;
            OFS_CLR_LO:  dec_op = OP_CLR;
            default:     dec_ok = 1'b0;
        endcase
        st_nxt.sync1   = pin_in;
        st_nxt.sync2   = st_r.sync1;
        st_nxt.h_valid = 1'b0;
        st_nxt.ready   = 1'b0;
        if (st_r.pend) begin
            // second half of a wide access goes one cycle after the first
            st_nxt.pend    = 1'b0;
            st_nxt.ready   = 1'b1;
            if (st_r.pend_rd) begin
                st_nxt.rdata = {st_r.sync2[31:16], st_r.rd_lo};
            end else begin
                st_nxt.h_valid = 1'b1;
                st_nxt.h_hi    = 1'b1;
                st_nxt.h_op    = st_r.pend_op;
                st_nxt.h_data  = st_r.pend_data;
            end
        end else if (cfg_wr) begin
            st_nxt.ready = ~cfg_wide;
            if (cfg_addr == OFS_DIR_LO || cfg_addr == OFS_DIR_HI) begin
                if (hit_hi) st_nxt.dir[31:16] = cfg_wdata[15:0];
                else        st_nxt.dir[15:0]  = cfg_wdata[15:0];
                st_nxt.ready = 1'b1;
            end else if (cfg_addr == OFS_FNC_LO || cfg_addr == OFS_FNC_HI) begin
                if (hit_hi) st_nxt.fnc[31:16] = cfg_wdata[15:0];
                else        st_nxt.fnc[15:0]  = cfg_wdata[15:0];
                st_nxt.ready = 1'b1;
            end else if (dec_ok) begin
                st_nxt.h_valid = 1'b1;
                // a wide access at a high-half offset acts as a plain 16-bit one
                st_nxt.h_hi    = hit_hi;
                st_nxt.h_op    = dec_op;
                st_nxt.h_data  = cfg_wdata[15:0];
                if (cfg_wide && !hit_hi) begin
                    st_nxt.pend      = 1'b1;
                    st_nxt.pend_rd   = 1'b0;
                    st_nxt.pend_op   = dec_op;
                    st_nxt.pend_data = cfg_wdata[31:16];
                end else begin
                    st_nxt.ready = 1'b1;
                end
            end else begin
                st_nxt.ready = 1'b1;
            end
        end else if (cfg_rd) begin
            st_nxt.rdata = {16'h0000, RST_RDATA};
            st_nxt.ready = 1'b1;
            if (cfg_addr == OFS_DATA_LO || cfg_addr == OFS_DATA_HI) begin
                cur_lvl = hit_hi ? st_r.sync2[31:16] : st_r.sync2[15:0];
                if (cfg_wide && !hit_hi) begin
                    st_nxt.pend    = 1'b1;
                    st_nxt.pend_rd = 1'b1;
                    st_nxt.rd_lo   = cur_lvl;
                    st_nxt.ready   = 1'b0;
                end else begin
                    st_nxt.rdata = {16'h0000, cur_lvl};
                end
            end else if (cfg_addr == OFS_DIR_LO || cfg_addr == OFS_DIR_HI) begin
                st_nxt.rdata = {16'h0000, hit_hi ? st_r.dir[31:16] : st_r.dir[15:0]};
            end else if (cfg_addr == OFS_FNC_LO || cfg_addr == OFS_FNC_HI) begin
                st_nxt.rdata = {16'h0000, hit_hi ? st_r.fnc[31:16] : st_r.fnc[15:0]};
            end
        end
        st_nxt.pout  = latch;
        st_nxt.poe_n = ~(st_r.dir & ~st_r.fnc);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r           <= '0;
            st_r.dir       <= RST_DIR;
            st_r.fnc       <= RST_FNC;
            st_r.pout      <= RST_LATCH;
            st_r.poe_n     <= 32'hFFFF_FFFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg_rdata = st_r.rdata;
    assign cfg_ready = st_r.ready;
    assign pin_out   = st_r.pout;
    assign pin_oe_n  = st_r.poe_n;
endmodule
`default_nettype wire

/* psc_pkg.sv */
// package: offsets, widths and reset values of the set/clear output control block
// Function
// - set bit overrides earlier data or clear
// - set ignored for inputs or interface pins
// - 32-bit set write splits, low half first
// - low clear bit n drives pin n low
// - high clear bits map onto pins 31..16
// - clear bit overrides earlier data or set
// - zero bits leave output latch unchanged
// - clear ignored for inputs or interface pins
// - 32-bit clear write splits, low half first
// - set bit drives output pin high
// - data read returns actual pin level
package psc_pkg;
    localparam int          HALF_W       = 16;
    localparam int          PIN_W        = 32;
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] OFS_DATA_LO  = 12'hC30;
    localparam logic [11:0] OFS_DATA_HI  = 12'hC32;
    localparam logic [11:0] OFS_SET_LO   = 12'hC34;
    localparam logic [11:0] OFS_SET_HI   = 12'hC36;
    localparam logic [11:0] OFS_CLR_LO   = 12'hC38;
    localparam logic [11:0] OFS_CLR_HI   = 12'hC3A;
    localparam logic [11:0] OFS_DIR_LO   = 12'hC2C;
    localparam logic [11:0] OFS_DIR_HI   = 12'hC2E;
    localparam logic [11:0] OFS_FNC_LO   = 12'hC20;
    localparam logic [11:0] OFS_FNC_HI   = 12'hC22;
    localparam logic [31:0] RST_LATCH    = 32'h0000_0000;
    localparam logic [31:0] RST_DIR      = 32'h0000_0000;
    localparam logic [31:0] RST_FNC      = 32'h0000_0000;
    localparam logic [15:0] RST_RDATA    = 16'h0000;

    typedef enum logic [1:0] {
        OP_DATA,
        OP_SET,
        OP_CLR
    } psc_op_t;
endpackage

/* psc_half_if.sv */
// interface: one 16-bit latch update carried from the access splitter to the latch
`timescale 1ns/1ps
`default_nettype none
interface psc_half_if;
    import psc_pkg::*;
    logic          valid;
    logic          hi;
    psc_op_t       op;
    logic [15:0]   data;
    modport src (output valid, output hi, output op, output data);
    modport dst (input valid, input hi, input op, input data);
endinterface
`default_nettype wire

/* psc_latch.sv */
// module: 32-pin output latch updated one 16-bit half at a time
`timescale 1ns/1ps
`default_nettype none
module psc_latch
    import psc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // half-word update
    psc_half_if.dst          upd,
    // gating and result
    input  wire logic [31:0] dir_out,
    input  wire logic [31:0] fnc_sel,
    output logic      [31:0] latch
);
    typedef struct packed {
        logic [31:0] lat;
    } psc_lat_st_t;

    psc_lat_st_t st_r;
    psc_lat_st_t st_nxt;

    logic [31:0] wide;
    logic [31:0] lane;
    logic [31:0] gate;

    always_comb begin
        st_nxt = st_r;
        wide   = upd.hi ? {upd.data, 16'h0000} : {16'h0000, upd.data};
        lane   = upd.hi ? 32'hFFFF_0000 : 32'h0000_FFFF;
        // only output pins that are not on their interface function react
        gate   = dir_out & ~fnc_sel;
        if (upd.valid) begin
            unique case (upd.op)
                OP_DATA: st_nxt.lat = (st_r.lat & ~(lane & gate)) | (wide & lane & gate);
                OP_SET:  st_nxt.lat = st_r.lat | (wide & gate);
                OP_CLR:  st_nxt.lat = st_r.lat & ~(wide & gate);
                default: st_nxt.lat = st_r.lat;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r.lat <= RST_LATCH;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign latch = st_r.lat;
endmodule
`default_nettype wire

/* psc_asserts.sv */
// checker: gating and split timing of the set/clear ports
`timescale 1ns/1ps
`default_nettype none
module psc_asserts
    import psc_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // config access
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [11:0] cfg_addr,
    input wire logic        cfg_wide,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_ready,
    // pins
    input wire logic [31:0] pin_in,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic w16 = cfg_wr && !cfg_wide;
    wire logic w32 = cfg_wr && cfg_wide;
    // ****************************************
    // assertions
    // ****************************************
    a_set_high: assert property (w16 && cfg_addr == OFS_SET_LO && cfg_wdata[0]
        && !pin_oe_n[0] |-> ##[1:4] pin_out[0]) else $error("pin 0 not set");
    a_clr_low: assert property (w16 && cfg_addr == OFS_CLR_LO && cfg_wdata[0]
        && !pin_oe_n[0] |-> ##[1:4] !pin_out[0]) else $error("pin 0 not cleared");
    a_clr_hi_map: assert property (w16 && cfg_addr == OFS_CLR_HI && cfg_wdata[15]
        && !pin_oe_n[31] |-> ##[1:4] !pin_out[31]) else $error("pin 31 not cleared");
    a_set_gated: assert property (w16 && cfg_addr == OFS_SET_LO && cfg_wdata[1]
        && pin_oe_n[1] |=> $stable(pin_out[1])[*4]) else $error("gated pin set");
    a_clr_gated: assert property (w16 && cfg_addr == OFS_CLR_LO && cfg_wdata[1]
        && pin_oe_n[1] |=> $stable(pin_out[1])[*4]) else $error("gated pin cleared");
    a_zero_keep: assert property (w16 && cfg_addr == OFS_SET_LO && cfg_wdata[15:1] == 15'h0
        |=> $stable(pin_out[15:1])[*4]) else $error("zero bits moved pins");
    a_wide_set: assert property (w32 && cfg_addr == OFS_SET_LO && cfg_wdata == 32'hFFFFFFFF
        && pin_out == 32'h0 && pin_oe_n == 32'h0 |-> ##[1:4] pin_out == 32'h0000FFFF
        ##1 pin_out == 32'hFFFFFFFF) else $error("wide set not split low first");
    a_wide_clr: assert property (w32 && cfg_addr == OFS_CLR_LO && cfg_wdata == 32'hFFFFFFFF
        && pin_out == 32'hFFFFFFFF && pin_oe_n == 32'h0 |-> ##[1:4] pin_out == 32'hFFFF0000
        ##1 pin_out == 32'h0) else $error("wide clear not split low first");
    c_wide: cover property (w32);
    c_read: cover property (cfg_rd ##1 cfg_ready);
    c_gated: cover property (cfg_wr && pin_oe_n[1]);
endmodule
bind psc_top psc_asserts u_chk (.clk_sys, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wide,
    .cfg_wdata, .cfg_rdata, .cfg_ready, .pin_in, .pin_out, .pin_oe_n);
`default_nettype wire

/* psc_pins.sv */
// partner: loads and drivers outside the port pins
`timescale 1ns/1ps
`default_nettype none
module psc_pins (
    // port side
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe_n,
    // far side
    input  wire logic [31:0] ext_lvl,
    output logic      [31:0] pin_in
);
    // a released pin shows the outside level, never the stale latch
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule
`default_nettype wire

/* testbench.sv */
// testbench: register-level tests of the set/clear output control
`timescale 1ns/1ps
`default_nettype none
module testbench import psc_pkg::*;;
    logic        clk_sys, rst, cfg_wr, cfg_rd, cfg_wide, cfg_ready;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, pin_in, pin_out, pin_oe_n, ext_lvl;
    int          mismatches = 0;
    int          comparisons = 0;
    psc_top uut (.clk_sys, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wide, .cfg_wdata,
        .cfg_rdata, .cfg_ready, .pin_in, .pin_out, .pin_oe_n);
    psc_pins u_pins (.pin_out, .pin_oe_n, .ext_lvl, .pin_in);
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic wd,
                       input logic [31:0] d);
        int n = 0;
        @(negedge clk_sys);
        {cfg_wr, cfg_rd, cfg_addr, cfg_wide, cfg_wdata} = {w, !w, a, wd, d};
        @(negedge clk_sys);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        while (cfg_ready !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        if (cfg_ready !== 1'b1) begin
            mismatches++;
            results();
        end
    endtask
    task automatic wrc(input logic [11:0] a, input logic wd, input logic [31:0] d,
                       input logic [31:0] e);
        acc(1'b1, a, wd, d);
        repeat (3) @(negedge clk_sys);
        chk(pin_out, e);
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        {cfg_wr, cfg_rd, cfg_wide, cfg_addr, cfg_wdata} = '0;
        rst = 1'b1;
        ext_lvl = 32'hC0000002;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        chk(pin_oe_n, 32'hFFFFFFFF);
        chk(pin_out, 32'h0);
        wrc(OFS_DIR_LO, 1'b0, 32'h0000FFFF, 32'h0);
        wrc(OFS_DIR_HI, 1'b0, 32'h0000FFFF, 32'h0);
        chk(pin_oe_n, 32'h0);
        wrc(OFS_SET_LO, 1'b1, 32'hFFFFFFFF, 32'hFFFFFFFF);
        wrc(OFS_CLR_LO, 1'b1, 32'hFFFFFFFF, 32'h0);
        // pin 1 to its interface function, pin 30 to input
        wrc(OFS_FNC_LO, 1'b0, 32'h00000002, 32'h0);
        wrc(OFS_DIR_HI, 1'b0, 32'h0000BFFF, 32'h0);
        chk(pin_oe_n, 32'h40000002);
        wrc(OFS_SET_LO, 1'b0, 32'h0000FFFF, 32'h0000FFFD);
        wrc(OFS_SET_HI, 1'b0, 32'h0000FFFF, 32'hBFFFFFFD);
        wrc(OFS_CLR_LO, 1'b0, 32'h00000001, 32'hBFFFFFFC);
        wrc(OFS_CLR_HI, 1'b0, 32'h00008000, 32'h3FFFFFFC);
        wrc(OFS_CLR_LO, 1'b0, 32'h00000002, 32'h3FFFFFFC);
        wrc(OFS_DATA_LO, 1'b0, 32'h0, 32'h3FFF0000);
        wrc(OFS_SET_LO, 1'b0, 32'h00000001, 32'h3FFF0001);
        wrc(12'hC3C, 1'b0, 32'h0000FFFF, 32'h3FFF0001);
        acc(1'b0, OFS_DATA_LO, 1'b1, 32'h0);
        chk(cfg_rdata, 32'h7FFF0003);
        ext_lvl = 32'h0;
        repeat (4) @(negedge clk_sys);
        acc(1'b0, OFS_DATA_LO, 1'b1, 32'h0);
        chk(cfg_rdata, 32'h3FFF0001);
        acc(1'b0, 12'hC3C, 1'b0, 32'h0);
        chk(cfg_rdata, 32'h0);
        wrc(OFS_SET_HI, 1'b1, 32'h00008000, 32'hBFFF0001);
        // reset in mid-run drops the latch and releases every pin
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        chk(pin_out, 32'h0);
        chk(pin_oe_n, 32'hFFFFFFFF);
        wrc(OFS_SET_LO, 1'b0, 32'h0000FFFF, 32'h0);
        results();
    end
endmodule
`default_nettype wire
